/* File: rpl_pkg.sv */
/*
 Package for the register preload and readback lock block.
 Assumes: all logic runs on mclk at 25 MHz with one active-low reset.
*/
package rpl_pkg;
   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int CELLS      = 10;
   localparam int CFG_AW     = 14;
   localparam int CFG_DW     = 8;
   // ----------------------------------------------------------------
   // Levels
   // ----------------------------------------------------------------
   localparam logic SEL_REG0   = 1'b0;
   localparam logic SEL_REG1   = 1'b1;
   localparam logic CELL_RESET = 1'b0;
   localparam logic LOCK_RESET = 1'b0;
   localparam logic [CFG_DW-1:0] CFG_ALL_PROG = 8'h00;
endpackage : rpl_pkg

/* File: rpl_prog.sv */
/*
 Programmer and tester model: configuration store and preload pins.
 Assumes: tasks are called just after a rising mclk edge.
*/
module rpl_prog (
   input  wire logic        mclk,          // Clock
   input  wire logic [13:0] cfg_cell_addr, // Store address
   output logic      [7:0]  cfg_cell,      // Stored cell data
   output logic             hv_mode_pin,   // Mode pin at high voltage
   output logic             sel_pin,       // Register select
   output logic             clk_term_pin,  // Register clock term
   output logic      [9:0]  io_in          // I/O pin levels
);
   timeunit 1ns;
   timeprecision 1ps;
   assign cfg_cell = cfg_cell_addr[7:0] ^ 8'h5A;
   initial begin
      {hv_mode_pin, sel_pin, clk_term_pin, io_in} = '0;
   end
   task automatic preload(input logic h, input logic s, input logic [9:0] v);
      hv_mode_pin <= h;
      sel_pin <= s;
      io_in <= v;
      repeat (5) @(posedge mclk);
      clk_term_pin <= 1'b1;
      repeat (5) @(posedge mclk);
      clk_term_pin <= 1'b0;
      repeat (5) @(posedge mclk);
      hv_mode_pin <= 1'b0;
      io_in <= ~v;
      repeat (5) @(posedge mclk);
   endtask : preload
endmodule : rpl_prog

/* File: rpl_sync.sv */
/*
 Two-flop synchroniser for a vector of pin levels.
 Assumes: inputs are asynchronous to clk; reset is already synchronised.
*/
module rpl_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,    // Clock
   input  wire logic         rst_n,  // Reset, active low
   input  wire logic [W-1:0] d,      // Asynchronous levels
   output logic      [W-1:0] q       // Synchronised levels
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_q;

   always_comb begin
      next_meta = d;
      next_q    = meta;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= next_meta;
         q    <= next_q;
      end
   end
endmodule : rpl_sync

/* File: rpl_tb_top.sv */
/*
 Bench for rpl_top with the programmer model.
 Assumes: package, design, checker and model compiled first.
*/
module rpl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk, rst_n, hv_mode_pin, sel_pin, clk_term_pin, cfg_rd;
   logic        cfg_rvalid, lock, lock_set, lock_erase, preload_mode;
   logic [9:0]  io_in, sum0, sum1, clk0, clk1, ares0, ares1, reg0, reg1, r;
   logic [13:0] cfg_addr, cfg_cell_addr;
   logic [7:0]  cfg_cell, cfg_rdata, lfsr;
   logic [7:0]  exp_q[$];
   int          num_errors, num_checks, cycles;
   rpl_top  i_dut (.*);
   rpl_prog i_prog (.*);
   function automatic logic [7:0] next_rand(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : next_rand
   task automatic check(input string what, input logic [9:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic stop_test();
      if (num_errors == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : stop_test
   task automatic reads(input logic lk);
      for (int k = 0; k < 4; k++) begin
         lfsr = next_rand(lfsr);
         cfg_addr <= {lfsr[5:0], lfsr};
         cfg_rd <= 1'b1;
         exp_q.push_back(lk ? rpl_pkg::CFG_ALL_PROG : lfsr ^ 8'h5A);
         @(posedge mclk);
      end
      cfg_rd <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask : reads
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cfg_rvalid === 1'b1)
         check("rdata", 10'(cfg_rdata), 10'(exp_q.pop_front()));
      if (cycles > 2000) begin
         num_errors++;
         stop_test();
      end
   end
   initial begin
      {rst_n, cfg_rd, lock_set, lock_erase, cfg_addr} = '0;
      {sum0, sum1, clk0, clk1, ares0, ares1} = '0;
      lfsr = 8'h56;
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      lfsr = next_rand(lfsr);
      r = {lfsr[1:0], lfsr};
      {ares0, ares1} <= '1;
      @(posedge mclk);
      {ares0, ares1, clk0, clk1} <= {20'h0_0000, 20'hF_FFFF};
      {sum0, sum1} <= {r, ~r};
      @(posedge mclk);
      {clk0, clk1} <= '0;
      @(posedge mclk);
      check("reg0", reg0, r);
      check("reg1", reg1, ~r);
      i_prog.preload(1'b0, 1'b0, ~r);
      check("idle", reg0, r);
      check("idle1", reg1, ~r);
      for (int k = 0; k < 4; k++) begin
         lfsr = next_rand(lfsr);
         r = {lfsr[1:0], lfsr};
         i_prog.preload(1'b1, k[0], r);
         check("preload", k[0] ? reg1 : reg0, r);
      end
      reads(1'b0);
      lock_set <= 1'b1;
      @(posedge mclk);
      lock_set <= 1'b0;
      @(posedge mclk);
      check("lock", {9'h000, lock}, 10'h001);
      reads(1'b1);
      // Erase wins over a set in the same cycle
      {lock_set, lock_erase} <= 2'b11;
      @(posedge mclk);
      {lock_set, lock_erase} <= 2'b00;
      @(posedge mclk);
      check("erase", {9'h000, lock}, 10'h000);
      reads(1'b0);
      check("pending", 10'(exp_q.size()), 10'h000);
      stop_test();
   end
endmodule : rpl_tb_top

/* File: rpl_top.sv */
/*
 Paired output-cell registers with a pin-driven preload path and a
 readback lock over the configuration verify port.
 Assumes: pins arrive asynchronously; normal sum, clock, reset terms and
 the configuration store come from the surrounding array logic on mclk.
*/
module rpl_top #(
   parameter int CELLS = rpl_pkg::CELLS,
   parameter int AW    = rpl_pkg::CFG_AW,
   parameter int DW    = rpl_pkg::CFG_DW
) (
   input  wire logic             mclk,         // Clock, 25 MHz
   input  wire logic             rst_n,        // Async reset, active low
   input  wire logic             hv_mode_pin,  // Mode pin at high voltage
   input  wire logic             sel_pin,      // Register select pin
   input  wire logic             clk_term_pin, // Register clock term pin
   input  wire logic [CELLS-1:0] io_in,        // I/O pin levels
   input  wire logic [CELLS-1:0] sum0,         // Sum terms, register 0
   input  wire logic [CELLS-1:0] sum1,         // Sum terms, register 1
   input  wire logic [CELLS-1:0] clk0,         // Clock terms, register 0
   input  wire logic [CELLS-1:0] clk1,         // Clock terms, register 1
   input  wire logic [CELLS-1:0] ares0,        // Resets, register 0, taken on mclk
   input  wire logic [CELLS-1:0] ares1,        // Resets, register 1, taken on mclk
   input  wire logic             lock_set,     // Program the lock bit
   input  wire logic             lock_erase,   // Erase clears the lock
   input  wire logic [AW-1:0]    cfg_addr,     // Verify address
   input  wire logic             cfg_rd,       // Verify read strobe
   input  wire logic [DW-1:0]    cfg_cell,     // Stored cell data
   output logic      [AW-1:0]    cfg_cell_addr,// Address to the store
   output logic      [DW-1:0]    cfg_rdata,    // Verify read data
   output logic                  cfg_rvalid,   // Verify data valid
   output logic                  lock,         // Lock state
   output logic                  preload_mode, // Force mode active
   output logic      [CELLS-1:0] reg0,         // Register 0 of each cell
   output logic      [CELLS-1:0] reg1          // Register 1 of each cell
);
   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic rst_m;
   logic rst_s;

   // Applied at once, released on an edge so no flop sees a runt
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rst_m <= 1'b0;
         rst_s <= 1'b0;
      end else begin
         rst_m <= 1'b1;
         rst_s <= rst_m;
      end
   end

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [CELLS+2:0] pins_s;
   logic             hv_s;
   logic             sel_s;
   logic             ct_s;
   logic [CELLS-1:0] io_s;

   // All pins share one synchroniser so mode, select, clock term and
   // data levels reach the logic in the same cycle
   rpl_sync #(.W(CELLS + 3)) u_sync (
      .clk   (mclk),
      .rst_n (rst_s),
      .d     ({hv_mode_pin, sel_pin, clk_term_pin, io_in}),
      .q     (pins_s)
   );

   always_comb begin
      hv_s  = pins_s[CELLS+2];
      sel_s = pins_s[CELLS+1];
      ct_s  = pins_s[CELLS];
      io_s  = pins_s[CELLS-1:0];
   end

   // ----------------------------------------------------------------
   // Preload control
   // ----------------------------------------------------------------
   logic ct_d;
   logic next_ct_d;
   logic next_mode;
   logic pulse;

   always_comb begin
      next_mode = hv_s;
      next_ct_d = ct_s;
      // rising clock term
      // A term held high loads only once
      pulse     = preload_mode && ct_s && !ct_d;
   end

   always_ff @(posedge mclk or negedge rst_s) begin
      if (!rst_s) begin
         preload_mode <= 1'b0;
         ct_d         <= 1'b0;
      end else begin
         preload_mode <= next_mode;
         ct_d         <= next_ct_d;
      end
   end

   // ----------------------------------------------------------------
   // Preload decode
   // ----------------------------------------------------------------
   logic load0;
   logic load1;

   // select picks the register
   // Only one register of the pair loads per pulse
   always_comb begin
      load0 = pulse && (sel_s == rpl_pkg::SEL_REG0);
      load1 = pulse && (sel_s == rpl_pkg::SEL_REG1);
   end

   // ----------------------------------------------------------------
   // Register pairs
   // ----------------------------------------------------------------
   logic [CELLS-1:0] next_reg0;
   logic [CELLS-1:0] next_reg1;

   always_comb begin
      next_reg0 = reg0;
      next_reg1 = reg1;
      for (int i = 0; i < CELLS; i++) begin
         if (preload_mode) begin
            if (load0) begin
               next_reg0[i] = io_s[i];
            end else if (load1) begin
               next_reg1[i] = io_s[i];
            end
         end else begin
            // normal terms only
            // The tester owns the cells while forcing
            if (ares0[i]) begin
               next_reg0[i] = rpl_pkg::CELL_RESET;
            end else if (clk0[i]) begin
               next_reg0[i] = sum0[i];
            end
            if (ares1[i]) begin
               next_reg1[i] = rpl_pkg::CELL_RESET;
            end else if (clk1[i]) begin
               next_reg1[i] = sum1[i];
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_s) begin
      if (!rst_s) begin
         reg0 <= {CELLS{rpl_pkg::CELL_RESET}};
         reg1 <= {CELLS{rpl_pkg::CELL_RESET}};
      end else begin
         reg0 <= next_reg0;
         reg1 <= next_reg1;
      end
   end

   // ----------------------------------------------------------------
   // Readback lock
   // ----------------------------------------------------------------
   logic next_lock;

   // Erase wins so a locked part can always be reprogrammed
   always_comb begin
      next_lock = lock;
      if (lock_erase) begin
         next_lock = rpl_pkg::LOCK_RESET;
      end else if (lock_set) begin
         next_lock = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_s) begin
      if (!rst_s) begin
         lock <= rpl_pkg::LOCK_RESET;
      end else begin
         lock <= next_lock;
      end
   end

   // ----------------------------------------------------------------
   // Verify port
   // ----------------------------------------------------------------
   logic [DW-1:0] next_rdata;
   logic          next_rvalid;

   always_comb begin
      cfg_cell_addr = cfg_addr;
      next_rvalid   = cfg_rd;
      next_rdata    = cfg_rdata;
      if (cfg_rd) begin
         // mask at once
         // A set in this cycle already masks, so no cell leaks
         if (lock || lock_set) begin
            next_rdata = rpl_pkg::CFG_ALL_PROG;
         end else begin
            next_rdata = cfg_cell;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_s) begin
      if (!rst_s) begin
         cfg_rdata  <= '0;
         cfg_rvalid <= 1'b0;
      end else begin
         cfg_rdata  <= next_rdata;
         cfg_rvalid <= next_rvalid;
      end
   end
endmodule : rpl_top

/* File: rpl_top_props.sv */
/*
 Port checker for rpl_top.
 Assumes: bound to rpl_top; tester holds preload pins 5 cycles.
*/
module rpl_props #(
   parameter int CELLS = 10,
   parameter int DW    = 8
) (
   input wire logic             mclk,         // Clock
   input wire logic             rst_n,        // Reset, active low
   input wire logic             hv_mode_pin,  // Mode pin
   input wire logic             sel_pin,      // Register select
   input wire logic [CELLS-1:0] io_in,        // I/O pin levels
   input wire logic [CELLS-1:0] sum0,         // Sum terms, register 0
   input wire logic [CELLS-1:0] sum1,         // Sum terms, register 1
   input wire logic [CELLS-1:0] clk0,         // Clock terms, register 0
   input wire logic [CELLS-1:0] clk1,         // Clock terms, register 1
   input wire logic [CELLS-1:0] ares0,        // Resets, register 0
   input wire logic [CELLS-1:0] ares1,        // Resets, register 1
   input wire logic             lock_set,     // Lock request
   input wire logic             lock_erase,   // Lock erase
   input wire logic             cfg_rd,       // Verify read strobe
   input wire logic [DW-1:0]    cfg_cell,     // Stored cell data
   input wire logic [DW-1:0]    cfg_rdata,    // Verify read data
   input wire logic             cfg_rvalid,   // Verify data valid
   input wire logic             lock,         // Lock state
   input wire logic             preload_mode, // Force mode active
   input wire logic [CELLS-1:0] reg0,         // Register 0 of each cell
   input wire logic [CELLS-1:0] reg1          // Register 1 of each cell
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   property p_rd_valid;
      cfg_rd |=> cfg_rvalid;
   endproperty
   a_rd_valid: assert property (p_rd_valid)
      else $error("read not answered");
   property p_rd_data;
      cfg_rd && !lock && !lock_set |=> cfg_rdata == $past(cfg_cell);
   endproperty
   a_rd_data: assert property (p_rd_data)
      else $error("unlocked read data wrong");
   property p_lock_mask;
      cfg_rvalid && lock |-> cfg_rdata == rpl_pkg::CFG_ALL_PROG;
   endproperty
   a_lock_mask: assert property (p_lock_mask)
      else $error("locked read not masked");
   property p_mode;
      preload_mode |-> $past(hv_mode_pin, 3);
   endproperty
   a_mode: assert property (p_mode)
      else $error("force mode without mode pin");
   property p_norm;
      !preload_mode ##1 !preload_mode |-> reg0 == (~$past(ares0) &
         ($past(clk0) & $past(sum0) | ~$past(clk0) & $past(reg0)));
   endproperty
   a_norm: assert property (p_norm)
      else $error("register 0 normal update wrong");
   property p_pre0;
      $past(preload_mode) && reg0 != $past(reg0) |->
         $past(sel_pin, 3) == rpl_pkg::SEL_REG0 && reg0 == $past(io_in, 3);
   endproperty
   a_pre0: assert property (p_pre0)
      else $error("register 0 preload wrong");
   property p_pre1;
      $past(preload_mode) && reg1 != $past(reg1) |->
         $past(sel_pin, 3) == rpl_pkg::SEL_REG1 && reg1 == $past(io_in, 3);
   endproperty
   a_pre1: assert property (p_pre1)
      else $error("register 1 preload wrong");
   property p_norm1;
      !preload_mode ##1 !preload_mode |-> reg1 == (~$past(ares1) &
         ($past(clk1) & $past(sum1) | ~$past(clk1) & $past(reg1)));
   endproperty
   a_norm1: assert property (p_norm1)
      else $error("register 1 normal update wrong");
   property p_lock_rise;
      $rose(lock) |-> $past(lock_set) && !$past(lock_erase);
   endproperty
   a_lock_rise: assert property (p_lock_rise)
      else $error("lock set without request");
   property p_lock_erase;
      lock_erase |=> !lock;
   endproperty
   a_lock_erase: assert property (p_lock_erase)
      else $error("lock not cleared by erase");
endmodule : rpl_props

bind rpl_top rpl_props #(.CELLS(CELLS), .DW(DW)) i_props (.*);
